//--- testbench/pmx_monitor.sv
// Port-level assertions of the pin function select
`timescale 1ns/10ps
module pmx_monitor (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic [4:0]  tport_in,
  input wire logic [3:0]  timer_io_level,
  input wire logic        timer_ext_clock_in,
  input wire logic [3:0]  analog_in_sel,
  input wire logic        upper_ref_input,
  input wire logic        lower_ref_input
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  property p_resp; hresp == 1'b0; endproperty
  a_resp: assert property (p_resp) else $error("response not okay");
  // Exactly one wait state per accepted transfer
  property p_wait;
    (hsel && htrans[1] && hready && hreadyout) |=> !hreadyout ##1 hreadyout;
  endproperty
  a_wait: assert property (p_wait) else $error("wait state count wrong");
  // Read data only moves on a completion edge
  property p_rdata; $changed(hrdata) |-> !$past(hreadyout); endproperty
  a_rdata: assert property (p_rdata) else $error("read data moved early");
  // Guard on the edge after reset, when the flop still holds reset values
  property p_clkin;
    $past(rst_n) |-> timer_ext_clock_in == $past(tport_in[0]);
  endproperty
  a_clkin: assert property (p_clkin) else $error("clock pin lost");
  property p_iolvl;
    $past(rst_n) |-> timer_io_level == $past(tport_in[4:1]);
  endproperty
  a_iolvl: assert property (p_iolvl) else $error("timer input lost");
  property p_refs; upper_ref_input == lower_ref_input; endproperty
  a_refs: assert property (p_refs) else $error("refs disagree");
  property p_scan;
    analog_in_sel[2] && analog_in_sel[1] |-> analog_in_sel[0];
  endproperty
  a_scan: assert property (p_scan) else $error("scan claim wrong");
  property p_an3;
    analog_in_sel[3] && !analog_in_sel[0] |-> analog_in_sel[2:1] == 2'b00;
  endproperty
  a_an3: assert property (p_an3) else $error("channel 3 claim wrong");
endmodule

bind pmx_top pmx_monitor pmx_monitor_i (
  .clock, .rst_n, .hsel, .htrans, .hready, .hreadyout, .hresp, .hrdata,
  .tport_in, .timer_io_level, .timer_ext_clock_in, .analog_in_sel,
  .upper_ref_input, .lower_ref_input
);

//--- testbench/pmx_pad_model.sv
// Pad and outside-world model of the timer port
`timescale 1ns/10ps
module pmx_pad_model (
  input  wire logic [4:0] tport_out,
  input  wire logic [4:0] tport_oe,
  input  wire logic [4:0] ext_lvl,
  output logic [4:0]      tport_in
);
  // Chip wins where it drives; a real board would show contention here
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      tport_in[i] = tport_oe[i] ? tport_out[i] : ext_lvl[i];
    end
  end
endmodule

//--- testbench/tb_top.sv
// Self-checking bench of the timer port and input port pin select
`timescale 1ns/10ps
module tb_top;
  logic        clock, rst_n, hsel, hwrite, hresp, hreadyout;
  logic        timer_ext_clock_in, upper_ref_input, lower_ref_input;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize, pwm_wave_bcd;
  logic [4:0]  tport_in, tport_out, tport_oe, ext_lvl;
  logic [3:0]  cmp_out_abcd, timer_io_level, iport_in, analog_in_sel;
  int          fails;
  int          checks;

  pmx_top pmx_top_i (
    .clock, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .tport_in,
    .tport_out, .tport_oe, .pwm_wave_bcd, .cmp_out_abcd, .timer_io_level,
    .timer_ext_clock_in, .iport_in, .analog_in_sel, .upper_ref_input,
    .lower_ref_input
  );
  pmx_pad_model pmx_pad_model_i (.tport_out, .tport_oe, .ext_lvl, .tport_in);

  // Clock at 25 MHz
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One single word transfer; waits on hreadyout, never on a fixed count
  task automatic ahb(input logic [7:0] a, input logic w,
                     input logic [31:0] wd);
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(a, 1'b1, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    ahb(a, 1'b0, 32'h0);
    chk(rd, exp);
  endtask

  // Two edges: one for the pad flops, one for the timer-side flops
  task automatic settle;
    repeat (2) @(posedge clock);
  endtask

  task automatic t_reset;
    settle();
    chk(32'(hreadyout), 32'h1);
    chk(32'(hresp), 32'h0);
    chk(32'(tport_oe), 32'h0);
    chk(32'(analog_in_sel), 32'h1);
    chk(32'({upper_ref_input, lower_ref_input}), 32'h3);
    rdc(8'h08, 32'h2);
    $display("t_reset done");
  endtask

  // Every control code with both direction settings on all four channels
  task automatic t_decode;
    logic [3:0] own;
    logic [3:0] oe4;
    logic [3:0] out4;
    logic [3:0] pad;
    cmp_out_abcd <= 4'hf;
    wr(8'h0c, 32'h0);
    wr(8'h04, 32'h0a);
    for (int s = 0; s < 16; s++) begin
      own  = (s[2:0] != 3'h0 && !s[2]) ? 4'hf : 4'h0;
      oe4  = own | {4{s[3]}};
      out4 = own | (4'h5 & ~own);
      pad  = (oe4 & out4) | (~oe4 & 4'ha);
      wr(8'h00, s[3] ? 32'h1f : 32'h0);
      wr(8'h10, {25'h0, s[2:0], 1'b0, s[2:0]});
      wr(8'h14, {25'h0, s[2:0], 1'b0, s[2:0]});
      settle();
      chk(32'(tport_oe), 32'({oe4, s[3]}));
      chk(32'(tport_out), 32'({out4, 1'b0}));
      chk(32'(timer_io_level), 32'(pad));
      chk(32'(timer_ext_clock_in), 32'(!s[3]));
      rdc(8'h04, s[3] ? 32'h0a : 32'({pad, 1'b1}));
    end
    $display("t_decode done");
  endtask

  // PWM enables override a control field that asks for port input
  task automatic t_pwm;
    wr(8'h10, 32'h0);
    wr(8'h14, 32'h0);
    wr(8'h00, 32'h0);
    pwm_wave_bcd <= 3'b101;
    for (int e = 0; e < 8; e++) begin
      wr(8'h0c, 32'(e));
      settle();
      chk(32'(tport_oe), 32'({e[2:0], 2'b00}));
      chk(32'(tport_out[4:2] & e[2:0]), 32'(3'b101 & e[2:0]));
    end
    // Compare codes and output direction must not disturb a PWM pin
    wr(8'h00, 32'h1f);
    wr(8'h10, 32'h11);
    wr(8'h14, 32'h11);
    rdc(8'h14, 32'h11);
    settle();
    chk(32'(tport_out[4:2]), 32'h5);
    chk(32'(tport_oe), 32'h1f);
    $display("t_pwm done");
  endtask

  // All channel, scan and reference settings against the level register
  task automatic t_iport;
    logic [2:0] c;
    logic       sc;
    logic       ir;
    logic [3:0] an;
    logic [3:0] cl;
    for (int s = 0; s < 32; s++) begin
      c     = s[2:0];
      sc    = s[3];
      ir    = s[4];
      an[3] = c == 3'h3;
      an[2] = (!sc && c == 3'h2) || (sc && c[2:1] == 2'b01);
      an[1] = (c == 3'h1) || (sc && c[2:1] == 2'b01);
      an[0] = (!sc && c == 3'h0) || (sc && !c[2]);
      cl    = an | {!ir, !ir, 2'b00};
      iport_in <= 4'(s * 5);
      wr(8'h18, {27'h0, sc, 1'b0, c});
      wr(8'h1c, {31'h0, ir});
      settle();
      chk(32'(analog_in_sel), 32'(an));
      chk(32'({upper_ref_input, lower_ref_input}), 32'({!ir, !ir}));
      rdc(8'h08, {28'h0, iport_in & ~cl});
    end
    wr(8'h08, 32'hff);
    rdc(8'h08, {28'h0, iport_in & ~cl});
    wr(8'h40, 32'h5a);
    rdc(8'h40, 32'h0);
    $display("t_iport done");
  endtask

  task automatic results;
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Main sequence: all inputs defined at time zero, reset for 8 cycles
  initial begin
    fails = 0;
    checks = 0;
    rst_n = 1'b0;
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    pwm_wave_bcd = 3'h0;
    cmp_out_abcd = 4'h0;
    iport_in = 4'hf;
    ext_lvl = 5'h15;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_decode();
    t_pwm();
    t_iport();
    results();
  end

  // Whole run needs under 2000 cycles; this limit only catches a hang
  initial begin
    repeat (20000) @(posedge clock);
    fails++;
    results();
  end
endmodule

//--- verilog/pmx_map.svh
// Register offsets, field positions and reset values of the pin mux
`ifndef PMX_MAP_SVH
`define PMX_MAP_SVH

// Byte offsets of the register words
`define PMX_OFS_TIMER_PORT_DIRECTION 8'h00
`define PMX_OFS_TIMER_PORT_DATA      8'h04
`define PMX_OFS_INPUT_PORT_LEVELS    8'h08
`define PMX_OFS_GP_TIMER_MODE_REG    8'h0c
`define PMX_OFS_GP_TIMER_IO_CTRL_AB  8'h10
`define PMX_OFS_GP_TIMER_IO_CTRL_CD  8'h14
`define PMX_OFS_CONVERTER_CTRL       8'h18
`define PMX_OFS_VOLTAGE_DETECT_CTRL  8'h1c

// Field positions
`define PMX_POS_PWM_B     0
`define PMX_POS_PWM_C     1
`define PMX_POS_PWM_D     2
`define PMX_POS_IO_LO     0
`define PMX_POS_IO_HI     4
`define PMX_POS_SCAN      4
`define PMX_POS_INT_REF   0

// Reset values
`define PMX_RST_DIR       5'h00
`define PMX_RST_DATA      5'h00
`define PMX_RST_PWM       3'h0
`define PMX_RST_IO_SEL    3'h0
`define PMX_RST_CHAN_SEL  3'h0
`define PMX_RST_SCAN      1'h0
`define PMX_RST_INT_REF   1'h0

`endif

//--- verilog/pmx_pin_sel.sv
// Function select of one timer port pin
`timescale 1ns/10ps
module pmx_pin_sel (
  input  pmx_pkg::pmx_pin_ctrl_type  ctrl,
  output pmx_pkg::pmx_pin_drive_type drive
);

  // PWM first, then compare output, then the port itself
  always_comb begin
    if (ctrl.pwm_en) begin
      drive.out = ctrl.pwm_wave;
      drive.oe  = 1'b1;
    end else if (pmx_pkg::pmx_io_is_output(ctrl.io_sel)) begin
      drive.out = ctrl.cmp_out;
      drive.oe  = 1'b1;
    end else begin
      // Codes 000 and 1xx leave the pin to the port
      drive.out = ctrl.data;
      drive.oe  = ctrl.dir;
    end
  end

endmodule

//--- verilog/pmx_pkg.sv
// Types and shared decode of the pin mux
package pmx_pkg;

  // Everything that steers one timer port pin
  typedef struct packed {
    logic       pwm_en;
    logic       pwm_wave;
    logic [2:0] io_sel;
    logic       cmp_out;
    logic       dir;
    logic       data;
  } pmx_pin_ctrl_type;

  // What the pad receives
  typedef struct packed {
    logic out;
    logic oe;
  } pmx_pin_drive_type;

  // Converter settings that claim input port pins
  typedef struct packed {
    logic [2:0] chan_sel;
    logic       scan;
  } pmx_adc_ctrl_type;

  typedef enum logic [0:0] {
    pmx_bus_idle = 1'b0,
    pmx_bus_wait = 1'b1
  } pmx_bus_state_type;

  // Timer owns the pin only for codes 001, 010 and 011
  function automatic logic pmx_io_is_output(input logic [2:0] sel);
    pmx_io_is_output = !sel[2] && (sel[1:0] != 2'b00);
  endfunction

endpackage

//--- verilog/pmx_portb_sel.sv
// Analog and reference claims on the input-only port
`timescale 1ns/10ps
module pmx_portb_sel (
  input  pmx_pkg::pmx_adc_ctrl_type adc,
  input  wire logic                 int_ref,
  output logic [3:0]                analog_sel,
  output logic                      upper_ref,
  output logic                      lower_ref,
  output logic [3:0]                claimed
);

  // Channel select and scan decode per pin
  always_comb begin
    analog_sel[3] = adc.chan_sel == 3'h3;
    analog_sel[2] = (!adc.scan && adc.chan_sel == 3'h2) ||
                    (adc.scan && adc.chan_sel[2:1] == 2'h1);
    analog_sel[1] = (adc.chan_sel == 3'h1) ||
                    (adc.scan && adc.chan_sel[2:1] == 2'h1);
    analog_sel[0] = (!adc.scan && adc.chan_sel == 3'h0) ||
                    (adc.scan && !adc.chan_sel[2]);
    // External detector references whenever the internal one is off
    upper_ref = !int_ref;
    lower_ref = !int_ref;
    claimed   = analog_sel | {upper_ref, lower_ref, 2'b00};
  end

endmodule

//--- verilog/pmx_top.sv
// Timer port and input-only port pin function select with AHB-Lite slave
//
// Notes on behaviour
// - PWM mode bit set routes the PWM waveform; other controls ignored.
// - PWM off, control field 000: port I/O by direction bit.
// - PWM off, top bit 0, a lower bit 1: compare output drives pin.
// - PWM off, top bit 1: capture use, port I/O by direction bit.
// - Channel-A pin has no PWM bit, otherwise same control decode.
// - Clock pin direction from its direction bit; always feeds the timer.
// - Channel-D pin: PWM bit, then control field, then direction bit.
// - Input port: four pins on level register bits 3 to 0.
// - Level register reads 0 for pins claimed as analog or reference.
// - Pins 2 to 0 become analog per channel select and scan.
// - Pin 3 analog at channel 3; upper reference when internal off.
// - Pin 2 lower reference when internal reference is off.
// - Timer settings beat port registers; clock pin always reaches timer.
// - Timer port data read: stored value if output, else pin level.
`timescale 1ns/10ps
`include "pmx_map.svh"
module pmx_top (
  input  wire logic        clock,
  input  wire logic        rst_n,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Timer port pads, bit 0 clock pin, bits 1 to 4 channels A to D
  input  wire logic [4:0]  tport_in,
  output logic [4:0]       tport_out,
  output logic [4:0]       tport_oe,
  // Timer side
  input  wire logic [2:0]  pwm_wave_bcd,
  input  wire logic [3:0]  cmp_out_abcd,
  output logic [3:0]       timer_io_level,
  output logic             timer_ext_clock_in,
  // Input-only port pads
  input  wire logic [3:0]  iport_in,
  output logic [3:0]       analog_in_sel,
  output logic             upper_ref_input,
  output logic             lower_ref_input
);

  // Software state
  logic [4:0]                 timer_port_direction;
  logic [4:0]                 timer_port_data;
  logic [2:0]                 pwm_enable;
  logic [2:0]                 io_sel_a;
  logic [2:0]                 io_sel_b;
  logic [2:0]                 io_sel_c;
  logic [2:0]                 io_sel_d;
  pmx_pkg::pmx_adc_ctrl_type  converter_ctrl_status;
  logic                       internal_ref_select;
  logic [4:0]                 next_direction;
  logic [4:0]                 next_data;
  logic [2:0]                 next_pwm_enable;
  logic [2:0]                 next_io_sel_a;
  logic [2:0]                 next_io_sel_b;
  logic [2:0]                 next_io_sel_c;
  logic [2:0]                 next_io_sel_d;
  pmx_pkg::pmx_adc_ctrl_type  next_converter;
  logic                       next_internal_ref;

  // Bus state
  pmx_pkg::pmx_bus_state_type bus_state;
  pmx_pkg::pmx_bus_state_type next_bus_state;
  logic [7:0]                 bus_addr;
  logic                       bus_write;
  logic [7:0]                 next_bus_addr;
  logic                       next_bus_write;
  logic [31:0]                next_hrdata;
  logic                       next_hreadyout;

  // Pin side
  pmx_pkg::pmx_pin_ctrl_type  pin_ctrl [5];
  pmx_pkg::pmx_pin_drive_type pin_drive [5];
  logic [4:0]                 next_tport_out;
  logic [4:0]                 next_tport_oe;
  logic [3:0]                 port_analog;
  logic                       port_upper;
  logic                       port_lower;
  logic [3:0]                 port_claimed;
  logic [7:0]                 input_port_levels;
  logic [7:0]                 timer_data_read;

  // Per-pin control bundles; the clock pin has no timer output at all
  always_comb begin
    pin_ctrl[0] = '{pwm_en: 1'b0, pwm_wave: 1'b0, io_sel: 3'h0,
                    cmp_out: 1'b0, dir: timer_port_direction[0],
                    data: timer_port_data[0]};
    pin_ctrl[1] = '{pwm_en: 1'b0, pwm_wave: 1'b0, io_sel: io_sel_a,
                    cmp_out: cmp_out_abcd[0],
                    dir: timer_port_direction[1],
                    data: timer_port_data[1]};
    pin_ctrl[2] = '{pwm_en: pwm_enable[0], pwm_wave: pwm_wave_bcd[0],
                    io_sel: io_sel_b, cmp_out: cmp_out_abcd[1],
                    dir: timer_port_direction[2],
                    data: timer_port_data[2]};
    pin_ctrl[3] = '{pwm_en: pwm_enable[1], pwm_wave: pwm_wave_bcd[1],
                    io_sel: io_sel_c, cmp_out: cmp_out_abcd[2],
                    dir: timer_port_direction[3],
                    data: timer_port_data[3]};
    pin_ctrl[4] = '{pwm_en: pwm_enable[2], pwm_wave: pwm_wave_bcd[2],
                    io_sel: io_sel_d, cmp_out: cmp_out_abcd[3],
                    dir: timer_port_direction[4],
                    data: timer_port_data[4]};
  end

  // One selector per pin keeps the priority in a single place
  for (genvar i = 0; i < 5; i++) begin : g_pin
    pmx_pin_sel u_sel (
      .ctrl  (pin_ctrl[i]),
      .drive (pin_drive[i])
    );
  end

  pmx_portb_sel u_portb (
    .adc        (converter_ctrl_status),
    .int_ref    (internal_ref_select),
    .analog_sel (port_analog),
    .upper_ref  (port_upper),
    .lower_ref  (port_lower),
    .claimed    (port_claimed)
  );

  // Pad drive gathered for the output flops
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      next_tport_out[i] = pin_drive[i].out;
      next_tport_oe[i]  = pin_drive[i].oe;
    end
  end

  // Read views of the two data registers
  always_comb begin
    input_port_levels = {4'h0, iport_in & ~port_claimed};
    timer_data_read   = {3'h0,
      (timer_port_direction & timer_port_data) |
      (~timer_port_direction & tport_in)};
  end

  // Bus: one wait state per transfer, so a read right after a write
  // already sees the updated register state
  always_comb begin
    next_bus_state    = bus_state;
    next_bus_addr     = bus_addr;
    next_bus_write    = bus_write;
    next_hrdata       = hrdata;
    next_hreadyout    = hreadyout;
    next_direction    = timer_port_direction;
    next_data         = timer_port_data;
    next_pwm_enable   = pwm_enable;
    next_io_sel_a     = io_sel_a;
    next_io_sel_b     = io_sel_b;
    next_io_sel_c     = io_sel_c;
    next_io_sel_d     = io_sel_d;
    next_converter    = converter_ctrl_status;
    next_internal_ref = internal_ref_select;
    unique case (bus_state)
      pmx_pkg::pmx_bus_idle: begin
        if (hsel && htrans[1] && hready) begin
          next_bus_state = pmx_pkg::pmx_bus_wait;
          next_bus_addr  = haddr[7:0];
          next_bus_write = hwrite;
          next_hreadyout = 1'b0;
        end
      end
      pmx_pkg::pmx_bus_wait: begin
        next_bus_state = pmx_pkg::pmx_bus_idle;
        next_hreadyout = 1'b1;
        next_hrdata    = 32'h0000_0000;
        if (bus_write) begin
          // The level register has no write path
          case (bus_addr)
            `PMX_OFS_TIMER_PORT_DIRECTION: next_direction = hwdata[4:0];
            `PMX_OFS_TIMER_PORT_DATA:      next_data      = hwdata[4:0];
            `PMX_OFS_GP_TIMER_MODE_REG:
              next_pwm_enable = hwdata[`PMX_POS_PWM_D:`PMX_POS_PWM_B];
            `PMX_OFS_GP_TIMER_IO_CTRL_AB: begin
              next_io_sel_a = hwdata[`PMX_POS_IO_LO +: 3];
              next_io_sel_b = hwdata[`PMX_POS_IO_HI +: 3];
            end
            `PMX_OFS_GP_TIMER_IO_CTRL_CD: begin
              next_io_sel_c = hwdata[`PMX_POS_IO_LO +: 3];
              next_io_sel_d = hwdata[`PMX_POS_IO_HI +: 3];
            end
            `PMX_OFS_CONVERTER_CTRL: begin
              next_converter.chan_sel = hwdata[2:0];
              next_converter.scan     = hwdata[`PMX_POS_SCAN];
            end
            `PMX_OFS_VOLTAGE_DETECT_CTRL:
              next_internal_ref = hwdata[`PMX_POS_INT_REF];
            default: ;
          endcase
        end else begin
          // Unmapped offsets read as zero
          case (bus_addr)
            `PMX_OFS_TIMER_PORT_DIRECTION:
              next_hrdata = {27'h0, timer_port_direction};
            `PMX_OFS_TIMER_PORT_DATA:
              next_hrdata = {24'h0, timer_data_read};
            `PMX_OFS_INPUT_PORT_LEVELS:
              next_hrdata = {24'h0, input_port_levels};
            `PMX_OFS_GP_TIMER_MODE_REG:
              next_hrdata = {29'h0, pwm_enable};
            `PMX_OFS_GP_TIMER_IO_CTRL_AB:
              next_hrdata = {25'h0, io_sel_b, 1'b0, io_sel_a};
            `PMX_OFS_GP_TIMER_IO_CTRL_CD:
              next_hrdata = {25'h0, io_sel_d, 1'b0, io_sel_c};
            `PMX_OFS_CONVERTER_CTRL:
              next_hrdata = {27'h0, converter_ctrl_status.scan, 1'b0,
                             converter_ctrl_status.chan_sel};
            `PMX_OFS_VOLTAGE_DETECT_CTRL:
              next_hrdata = {31'h0, internal_ref_select};
            default: next_hrdata = 32'h0000_0000;
          endcase
        end
      end
    endcase
  end

  // Bus and control registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bus_state             <= pmx_pkg::pmx_bus_idle;
      bus_addr              <= 8'h00;
      bus_write             <= 1'b0;
      hrdata                <= 32'h0000_0000;
      hreadyout             <= 1'b1;
      hresp                 <= 1'b0;
      timer_port_direction  <= `PMX_RST_DIR;
      timer_port_data       <= `PMX_RST_DATA;
      pwm_enable            <= `PMX_RST_PWM;
      io_sel_a              <= `PMX_RST_IO_SEL;
      io_sel_b              <= `PMX_RST_IO_SEL;
      io_sel_c              <= `PMX_RST_IO_SEL;
      io_sel_d              <= `PMX_RST_IO_SEL;
      converter_ctrl_status <= '{chan_sel: `PMX_RST_CHAN_SEL,
                                 scan: `PMX_RST_SCAN};
      internal_ref_select   <= `PMX_RST_INT_REF;
    end else begin
      bus_state             <= next_bus_state;
      bus_addr              <= next_bus_addr;
      bus_write             <= next_bus_write;
      hrdata                <= next_hrdata;
      hreadyout             <= next_hreadyout;
      hresp                 <= 1'b0; // Always OKAY
      timer_port_direction  <= next_direction;
      timer_port_data       <= next_data;
      pwm_enable            <= next_pwm_enable;
      io_sel_a              <= next_io_sel_a;
      io_sel_b              <= next_io_sel_b;
      io_sel_c              <= next_io_sel_c;
      io_sel_d              <= next_io_sel_d;
      converter_ctrl_status <= next_converter;
      internal_ref_select   <= next_internal_ref;
    end
  end

  // Pad outputs one flop behind the controls; timer-facing levels one flop behind the pads
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tport_out          <= 5'h00;
      tport_oe           <= 5'h00;
      timer_io_level     <= 4'h0;
      timer_ext_clock_in <= 1'b0;
      analog_in_sel      <= 4'h0;
      upper_ref_input    <= 1'b0;
      lower_ref_input    <= 1'b0;
    end else begin
      tport_out          <= next_tport_out;
      tport_oe           <= next_tport_oe;
      // Timer always observes its pins, whoever drives them
      timer_io_level     <= tport_in[4:1];
      timer_ext_clock_in <= tport_in[0];
      analog_in_sel      <= port_analog;
      upper_ref_input    <= port_upper;
      lower_ref_input    <= port_lower;
    end
  end

endmodule
